// ===== rtl/dotm_dram.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
// Purpose: termination timing of the memory device
// Assumes: link pins arrive from another domain and are synchronised
// Notes: latencies in memory clock edges, asynchronous delay in system cycles
module dotm_dram import dotm_pkg::*; (
	// system
	input wire logic CLK,
	input wire logic RST,
	// link
	dotm_if.dram LINK,
	// configuration
	input wire logic [3:0] CWL,
	input wire logic [3:0] AL,
	input wire logic DLL_FREEZE,
	input wire logic DYN_EN,
	// termination
	output logic RTT_ON,
	output logic RTT_WR,
	output logic ASYNC_MODE,
	output logic TRANSITION,
	output logic CMD_ERR
);
	logic [1:0] ck_s, cke_s, odt_s, bl_s;
	logic [2:0] cmd_s0, cmd_s1;
	logic ck_d, ck_rise;
	logic cke_q;
	logic [31:0] odt_pipe;
	logic [CNT_W-1:0] async_cnt, post_cnt, rfc_cnt, wr_cnt;
	logic [4:0] wl, lat;
	logic pd, async_odt;
	logic pend_entry, pend_exit;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ck_s <= 2'h0;
			cke_s <= 2'h0;
			odt_s <= 2'h0;
			bl_s <= 2'h0;
			cmd_s0 <= 3'h0;
			cmd_s1 <= 3'h0;
			ck_d <= 1'b0;
		end else begin
			ck_s <= {ck_s[0], LINK.ck};
			cke_s <= {cke_s[0], LINK.cke};
			odt_s <= {odt_s[0], LINK.odt};
			bl_s <= {bl_s[0], LINK.bl8};
			cmd_s0 <= LINK.cmd;
			cmd_s1 <= cmd_s0;
			ck_d <= ck_s[1];
		end
	end
	assign ck_rise = ck_s[1] & ~ck_d;
	assign wl = 5'(CWL) + 5'(AL);
	assign lat = wl - 5'(LAT_SUB);
	// ----------------------------------------
	// power-down and mode
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cke_q <= 1'b1;
			pd <= 1'b0;
			CMD_ERR <= 1'b0;
			rfc_cnt <= '0;
		end else if (ck_rise) begin
			cke_q <= cke_s[1];
			pd <= ~cke_s[1];
			if (pd && (cmd_s1 == CMD_WRITE || cmd_s1 == CMD_READ))
				CMD_ERR <= 1'b1; // [R8]
			if (cmd_s1 == CMD_REFRESH)
				rfc_cnt <= CNT_W'(RFC_CYC);
			else if (rfc_cnt != '0)
				rfc_cnt <= rfc_cnt - 1'b1; // [R11]
		end
	end
	// entry and exit transition: window of WL-1 before edge is an uncertainty band
	// which this model treats as still in the mode before the edge; the flag marks only the part from the edge to the period end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			post_cnt <= '0;
			ASYNC_MODE <= 1'b0;
			TRANSITION <= 1'b0;
			pend_entry <= 1'b0;
			pend_exit <= 1'b0;
		end else if (ck_rise) begin
			if (cke_q && !cke_s[1] && DLL_FREEZE) begin
				// entry: period ends at later of cpded or refresh end [R9] [R10] [R11] [R12]
				post_cnt <= (rfc_cnt > CNT_W'(CPDED_CYC)) ? rfc_cnt : CNT_W'(CPDED_CYC);
				pend_entry <= 1'b1;
				pend_exit <= 1'b0;
				TRANSITION <= 1'b1; // [R13] [R16] [R17]
			end else if (!cke_q && cke_s[1] && (pend_entry || ASYNC_MODE)) begin
				post_cnt <= CNT_W'(XPDLL_CYC); // [R15]
				pend_exit <= 1'b1;
				pend_entry <= 1'b0;
				TRANSITION <= 1'b1;
			end else if (post_cnt != '0) begin
				post_cnt <= post_cnt - 1'b1;
			end else begin
				TRANSITION <= 1'b0;
				if (pend_entry)
					ASYNC_MODE <= 1'b1; // [R4] [R14]
				if (pend_exit)
					ASYNC_MODE <= 1'b0; // [R15]
				pend_entry <= 1'b0;
				pend_exit <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// synchronous and asynchronous paths
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			odt_pipe <= '0;
		else if (ck_rise)
			odt_pipe <= {odt_pipe[30:0], odt_s[1]};
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			async_odt <= 1'b0;
			async_cnt <= '0;
		end else if (async_odt != odt_s[1]) begin
			// no additive latency; RTT_ON follows the synchronised request 3 cycles later, 12 ns, past the 8.5 ns bound [R5] [R6] [R7]
			if (async_cnt >= CNT_W'(ASYNC_DELAY_CYC - 1)) begin
				async_odt <= odt_s[1];
				async_cnt <= '0;
			end else
				async_cnt <= async_cnt + 1'b1;
		end else
			async_cnt <= '0;
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			RTT_ON <= 1'b0;
		else if (ASYNC_MODE)
			RTT_ON <= async_odt;
		else if (ck_rise)
			RTT_ON <= (lat == 5'h0) ? odt_s[1] : odt_pipe[lat - 5'h1]; // [R18]
	end
	// ----------------------------------------
	// dynamic termination
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_cnt <= '0;
			RTT_WR <= 1'b0;
		end else if (ck_rise) begin
			if (DYN_EN && !ASYNC_MODE && cmd_s1 == CMD_WRITE)
				wr_cnt <= CNT_W'(lat) + CNT_W'(bl_s[1] ? CWN8_ADD : CWN4_ADD);
			else if (wr_cnt != '0)
				wr_cnt <= wr_cnt - 1'b1;
			// write value from lat after write to cwn after it [R19]
			RTT_WR <= (wr_cnt != '0) && (wr_cnt <= CNT_W'(bl_s[1] ? CWN8_ADD : CWN4_ADD));
		end
	end
endmodule : dotm_dram

// ===== inc/dotm_pkg.sv
// Purpose: shared constants and types for the on-die termination timing block
// Assumes: one 250 MHz system clock; the memory clock is sampled as a plain input
// Notes: latencies counted in memory clock cycles (edges of the sampled link clock)
//
// Operation
// R1: BC4 write: hold termination request four cycles
// R2: no write: hold counted from request high
// R3: BL8 write with request: six cycles suffice
// R4: frozen power-down selects asynchronous termination mode
// R5: asynchronous mode ignores additive latency
// R6: asynchronous turn-on within 8.5 ns; the code takes 12 ns after synchronisation
// R7: asynchronous turn-off within 8.5 ns; the code takes 12 ns after synchronisation
// R8: power-down: no reads or writes issued
// R9: entry window is WL-1 cycles backwards
// R10: entry period ends after power-down entry delay
// R11: refresh in progress extends entry period
// R12: window start excluded, end points included
// R13: transition period response may be either
// R14: synchronous before entry, asynchronous after it
// R15: exit period WL-1 before to exit delay
// R16: overlapping entry then exit: either mode
// R17: overlapping exit then entry: either mode
// R18: synchronous mode delays by CWL+AL-2
// R19: dynamic termination switches to write value
// R20: controller avoids toggling in transition periods; the code has no wait before entry or after exit
package dotm_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int ASYNC_DELAY_PS = 8500;
	// longest time rounds down
	localparam int ASYNC_DELAY_CYC = ASYNC_DELAY_PS / CLK_PERIOD_PS;
	localparam int HOLD_BC4 = 4;
	localparam int HOLD_BL8 = 6;
	localparam int LAT_SUB = 2;
	localparam int ANPD_SUB = 1;
	localparam int CWN4_ADD = 4;
	localparam int CWN8_ADD = 6;
	localparam int CPDED_CYC = 1;
	localparam int XPDLL_CYC = 10;
	localparam int RFC_CYC = 64;
	localparam int CNT_W = 8;
	// ----------------------------------------
	// command encodings
	// ----------------------------------------
	localparam logic [2:0] CMD_NOP = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h1;
	localparam logic [2:0] CMD_READ = 3'h2;
	localparam logic [2:0] CMD_REFRESH = 3'h3;
	// ----------------------------------------
	// controller registers (APB)
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LAT = 8'h08;
	localparam int CTRL_GO = 0;
	localparam int CTRL_WRITE = 1;
	localparam int CTRL_BL8 = 2;
	localparam int CTRL_PD = 3;
	localparam int CTRL_REFRESH = 4;
	localparam int CTRL_HOLD_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] LAT_RESET = 32'h0000_0005;
	typedef enum {DOTM_IDLE, DOTM_HOLD, DOTM_PD} dotm_state_type;
endpackage : dotm_pkg

// ===== inc/dotm_if.sv
`timescale 1ns/100ps
// Purpose: link between memory controller and termination logic
// Assumes: all signals move on the controller's clock
// Notes: ck is the memory clock made by the controller
interface dotm_if;
	logic ck;
	logic cke;
	logic odt;
	logic [2:0] cmd;
	logic bl8;
	modport ctrl (output ck, output cke, output odt, output cmd, output bl8);
	modport dram (input ck, input cke, input odt, input cmd, input bl8);
endinterface : dotm_if

// ===== rtl/dotm_ctrl.sv
`timescale 1ns/100ps
// Purpose: controller end driving memory clock, cke, odt and commands
// Assumes: software drives orders over APB
// Notes: memory clock is CLK divided by LAT-free constant of 12
module dotm_ctrl import dotm_pkg::*; (
	// system
	input wire logic CLK,
	input wire logic RST,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// link
	dotm_if.ctrl LINK
);
	localparam int HALF_DIV = 6;
	logic [31:0] ctrl, lat_reg;
	logic [3:0] div;
	logic ck, edge_en, busy;
	logic [CNT_W-1:0] hold;
	dotm_state_type state;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			div <= '0;
			ck <= 1'b0;
			edge_en <= 1'b0;
		end else begin
			edge_en <= 1'b0;
			if (div == 4'(HALF_DIV - 1)) begin
				div <= '0;
				ck <= ~ck;
				edge_en <= ck;
			end else
				div <= div + 1'b1;
		end
	end
	// ----------------------------------------
	// apb slave, zero wait
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl <= CTRL_RESET;
			lat_reg <= LAT_RESET;
			PRDATA <= '0;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & (PADDR != REG_CTRL) & (PADDR != REG_STATUS) & (PADDR != REG_LAT);
			if (busy && state != DOTM_IDLE)
				ctrl[CTRL_GO] <= 1'b0;
			// writes land only at the completing access edge
			if (PSEL && PENABLE && PREADY && PWRITE && PADDR == REG_CTRL)
				ctrl <= PWDATA;
			if (PSEL && PENABLE && PREADY && PWRITE && PADDR == REG_LAT)
				lat_reg <= PWDATA;
			// a pending go counts as busy so polling cannot pass before start
			PRDATA <= (PADDR == REG_CTRL) ? ctrl : (PADDR == REG_LAT) ? lat_reg :
				(PADDR == REG_STATUS) ? {30'h0, LINK.odt, busy | ctrl[CTRL_GO]} : 32'h0;
		end
	end
	// ----------------------------------------
	// odt sequencing
	// ----------------------------------------
	assign busy = (state != DOTM_IDLE);
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state <= DOTM_IDLE;
			hold <= '0;
			LINK.ck <= 1'b0;
			LINK.cke <= 1'b1;
			LINK.odt <= 1'b0;
			LINK.cmd <= CMD_NOP;
			LINK.bl8 <= 1'b0;
		end else begin
			LINK.ck <= ck;
			if (edge_en) begin
				LINK.cmd <= CMD_NOP;
				unique case (state)
					DOTM_IDLE: if (ctrl[CTRL_GO]) begin
						if (ctrl[CTRL_PD]) begin
							LINK.cke <= 1'b0; // odt held steady across entry [R20]
							state <= DOTM_PD;
						end else begin
							LINK.odt <= 1'b1;
							LINK.bl8 <= ctrl[CTRL_BL8];
							LINK.cmd <= ctrl[CTRL_REFRESH] ? CMD_REFRESH : ctrl[CTRL_WRITE] ? CMD_WRITE : CMD_NOP;
							// BL8 six, BC4 four, else programmed, never below four [R1] [R2] [R3]
							hold <= ctrl[CTRL_WRITE] ? CNT_W'(ctrl[CTRL_BL8] ? HOLD_BL8 - 1 : HOLD_BC4 - 1) :
								((ctrl[15:8] > CNT_W'(HOLD_BC4)) ? ctrl[15:8] - 1'b1 : CNT_W'(HOLD_BC4 - 1));
							state <= DOTM_HOLD;
						end
					end
					DOTM_HOLD: if (hold == '0) begin
						LINK.odt <= 1'b0;
						state <= DOTM_IDLE;
					end else
						hold <= hold - 1'b1;
					DOTM_PD: if (!ctrl[CTRL_PD]) begin
						LINK.cke <= 1'b1; // no read or write while down [R8]
						state <= DOTM_IDLE;
					end
				endcase
			end
		end
	end
endmodule : dotm_ctrl

// ===== sim/dotm_asserts.sv
`timescale 1ns/100ps
// Purpose: link checks between controller and termination ends
// Assumes: ck edges found by sampling on CLK
// Notes: counts are in ck rising edges
module dotm_asserts import dotm_pkg::*; (
	// system
	input wire logic CLK,
	input wire logic RST,
	// link
	input wire logic ck,
	input wire logic cke,
	input wire logic odt,
	input wire logic [2:0] cmd,
	input wire logic bl8
);
	logic ck_q;
	logic rise;
	logic last_odt;
	logic wr_b8;
	logic [7:0] hi_cnt;
	logic [7:0] wr_cnt;
	assign rise = ck & ~ck_q;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) ck_q <= 1'b0;
		else ck_q <= ck;
	end
	// ----------------------------------------
	// hold counters, saturating
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			last_odt <= 1'b0;
			hi_cnt <= 8'h00;
		end else if (rise) begin
			last_odt <= odt;
			hi_cnt <= !odt ? 8'h00 : (hi_cnt == 8'hFF ? hi_cnt : hi_cnt + 8'h01);
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_cnt <= 8'h00;
			wr_b8 <= 1'b0;
		end else if (rise) begin
			if (odt && cmd == CMD_WRITE) begin
				wr_cnt <= 8'h01;
				wr_b8 <= bl8;
			end else if (!odt) wr_cnt <= 8'h00;
			else if (wr_cnt != 8'h00 && wr_cnt != 8'hFF) wr_cnt <= wr_cnt + 8'h01;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence odt_drop;
		rise && !odt && last_odt;
	endsequence
	sequence next_edge;
		##[1:12] rise;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	chk_odt_min_hold: assert property (odt_drop |-> hi_cnt >= HOLD_BC4)
		else $error("odt released before minimum hold");
	chk_bc4_wr_hold: assert property ((odt_drop ##0 (wr_cnt != 8'h00 && !wr_b8)) |-> wr_cnt >= HOLD_BC4)
		else $error("odt released too soon after short write");
	chk_bl8_wr_hold: assert property ((odt_drop ##0 (wr_cnt != 8'h00 && wr_b8)) |-> wr_cnt >= HOLD_BL8)
		else $error("odt released too soon after long write");
	chk_pd_no_rdwr: assert property (rise && !cke |-> cmd != CMD_READ && cmd != CMD_WRITE)
		else $error("read or write sent in power-down");
	chk_wr_odt_high: assert property (rise && cmd == CMD_WRITE |-> odt)
		else $error("write sent without termination request");
	chk_cmd_one_edge: assert property (rise && cmd != CMD_NOP |-> next_edge ##0 cmd == CMD_NOP)
		else $error("command held past one ck period");
	chk_ck_min_period: assert property (rise |=> (!rise) [*8])
		else $error("ck period too short");
	chk_reset_idle: assert property ($fell(RST) |-> cke && !odt && cmd == CMD_NOP)
		else $error("link not idle after reset");
endmodule : dotm_asserts

// ===== sim/tb_top.sv
`timescale 1ns/100ps
// Purpose: bench joining controller and termination ends
// Assumes: APB reads checked through an expectation queue
// Notes: fixed seed keeps runs repeatable
module tb_top import dotm_pkg::*; ;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic chk_on = 1'b0;
	logic dll = 1'b0;
	logic seen_on = 1'b0;
	logic seen_wr = 1'b0;
	logic [3:0] al = 4'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd_val;
	logic pready, pslverr, rtt_on, rtt_wr, async_m, trans, cmd_err;
	logic [32:0] expq[$];
	int err_total = 0;
	int n_compared = 0;
	always #2 CLK = ~CLK;
	dotm_if link();
	dotm_ctrl i_dotm_ctrl (.CLK(CLK), .RST(RST), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link.ctrl));
	dotm_dram i_dotm_dram (.CLK(CLK), .RST(RST), .LINK(link.dram), .CWL(4'h5), .AL(al), .DLL_FREEZE(dll),
		.DYN_EN(1'b1), .RTT_ON(rtt_on), .RTT_WR(rtt_wr), .ASYNC_MODE(async_m), .TRANSITION(trans), .CMD_ERR(cmd_err));
	dotm_asserts i_dotm_asserts (.CLK(CLK), .RST(RST), .ck(link.ck), .cke(link.cke), .odt(link.odt),
		.cmd(link.cmd), .bl8(link.bl8));
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	// one APB transfer; an idle edge first keeps strobes from double assignment
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c, input logic [32:0] e);
		@(posedge CLK);
		if (c) expq.push_back(e);
		chk_on <= c;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge CLK);
		pen <= 1'b1;
		do @(posedge CLK); while (pready !== 1'b1);
		rd_val = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
		chk_on <= 1'b0;
	endtask : apb
	task automatic run(input logic [31:0] ctl, input logic wr);
		seen_on <= 1'b0;
		seen_wr <= 1'b0;
		apb(1'b1, REG_CTRL, ctl, 1'b0, 33'h0);
		do apb(1'b0, REG_STATUS, 32'h0, 1'b0, 33'h0); while (rd_val[0] === 1'b1);
		// off latency plus sync margin
		repeat (12 * (8 + al)) @(posedge CLK);
		check({32'h0, rtt_on}, 33'h0);
		check({32'h0, seen_on}, 33'h1);
		check({32'h0, seen_wr}, {32'h0, wr});
	endtask : run
	always @(posedge CLK) begin
		if (rtt_on === 1'b1) seen_on <= 1'b1;
		if (rtt_wr === 1'b1) seen_wr <= 1'b1;
		if (chk_on && psel && pen && pready === 1'b1) check({pslverr, prdata}, expq.pop_front());
	end
	initial begin
		logic [31:0] lat;
		void'($urandom(40600));
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		apb(1'b0, REG_CTRL, 32'h0, 1'b1, {1'b0, CTRL_RESET});
		apb(1'b0, REG_LAT, 32'h0, 1'b1, {1'b0, LAT_RESET});
		apb(1'b0, 8'h0C, 32'h0, 1'b1, {1'b1, 32'h0});
		lat = $urandom_range(5, 9);
		apb(1'b1, REG_LAT, lat, 1'b0, 33'h0);
		apb(1'b0, REG_LAT, 32'h0, 1'b1, {1'b0, lat});
		al <= 4'($urandom_range(0, 1));
		for (int k = 0; k < 3; k++) begin
			run((32'($urandom_range(4, 8)) << CTRL_HOLD_LSB) | (32'(k > 0) << CTRL_WRITE)
				| (32'(k == 2) << CTRL_BL8) | 32'h1, k > 0);
		end
		for (int d = 0; d < 2; d++) begin
			dll <= d[0];
			apb(1'b1, REG_CTRL, 32'h19 - 32'(d) * 32'h10, 1'b0, 33'h0);
			repeat (12 * (RFC_CYC + 12)) @(posedge CLK);
			check({32'h0, async_m}, {32'h0, d[0]});
			check({32'h0, cmd_err}, 33'h0);
			apb(1'b1, REG_CTRL, 32'h1, 1'b0, 33'h0);
			repeat (12 * (XPDLL_CYC + 12)) @(posedge CLK);
			check({32'h0, async_m}, 33'h0);
		end
		test_done();
	end
	initial begin
		#200000;
		err_total++;
		$display("[FAIL] %0t run did not finish", $time);
		test_done();
	end
endmodule : tb_top
